/* File: verilog/desf_map.svh */
// register map and field layout of the error status flag block
// assumes inclusion by desf_pkg only; the design files use its macros without including it
`ifndef DESF_MAP_SVH
`define DESF_MAP_SVH
`define DESF_ADDR_IRQ_CTRL   8'hE0
`define DESF_ADDR_EN_A       8'hE1
`define DESF_ADDR_EN_B       8'hE2
`define DESF_ADDR_STAT_A     8'hE5
`define DESF_ADDR_STAT_B     8'hE6
`define DESF_BIT_SYNC        7
`define DESF_BIT_CSUM        6
`define DESF_BIT_HDR_UNFIX   5
`define DESF_BIT_HDR_FIX     4
`define DESF_BIT_LANE_PROTO  3
`define DESF_BIT_LEADER      2
`define DESF_BIT_PLL_UNLOCK  0
`define DESF_BIT_IRQ_EN      0
`define DESF_CHAN_LSB        2
`define DESF_CHAN_BITS       6
`define DESF_MASK_A          8'hFD
`define DESF_MASK_B          8'hFC
`define DESF_RESET_A         8'h01
`define DESF_RESET_B         8'h00
`define DESF_RESET_UNLOCK    1'b1
`define DESF_ZERO_BYTE       8'h00
`endif

/* File: verilog/desf_pkg.sv */
// types shared by the error status flag block
// assumes desf_map.svh sits beside it
`include "desf_map.svh"
package desf_pkg;
  typedef logic [7:0] desf_byte_type;
  typedef logic [`DESF_CHAN_BITS-1:0] desf_chan_type;
endpackage

/* File: verilog/desf_sync3.sv */
// three-stage synchroniser for one level from outside the clock domain
// a change counts once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module desf_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output var  logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // hold the last agreed value while stages two and three disagree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      level_out <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule // desf_sync3
`default_nettype wire

/* File: verilog/desf_chan_flags.sv */
// six sticky write-one-to-clear error flags for one receive channel
// assumes one-cycle event pulses from the channel packet processor
`timescale 1ns/100ps
`default_nettype none
module desf_chan_flags
  import desf_pkg::*;
#(
  parameter int N = `DESF_CHAN_BITS
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire desf_chan_type set_evt,
  input  wire desf_chan_type clr_ones,
  output var  desf_chan_type flags_q
);
  // the flag field layout is fixed, so only the documented width is served
  if (N != `DESF_CHAN_BITS) begin : g_bad_width
    $error("desf_chan_flags: N must be six");
  end

  // set wins over a clear in the same cycle; zeros leave flags alone
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr_ones) | set_evt;
    end
  end
endmodule // desf_chan_flags
`default_nettype wire

/* File: verilog/desf_top.sv */
// error status flags and interrupt logic of a dual-channel video bridge
// assumes event inputs are one-cycle pulses on clk from each channel's
// packet processor; pll lock arrives from another domain
//
// Notes on behaviour
// - bit 7 sets on a channel sync error (unexpected sync packet).
// - bit 6 sets on a payload checksum mismatch.
// - bit 5 sets on an uncorrectable header error.
// - bit 4 sets on a corrected single header error.
// - bit 3 sets on any low-level lane protocol error.
// - protocol flag covers sot/eot, escape, lp sync and false control.
// - lane merge failures also set the protocol flag.
// - bit 2 sets on a start-of-transmission leader bit error.
// - flags stay set until software writes one to them.
// - bit 0 of channel a sets on pll lock loss; resets to one.
// - channel a flags at channel_a_error_status bits 7..2, bit 1 reserved, reset zero.
// - channel b flags at channel_b_error_status bits 7..2, bits 1..0 reserved zero.
// - irq pin floats unless global enable at 0xE0 is set.
// - enable bits at 0xE1 and 0xE2 mask each flag from irq.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module desf_top
  import desf_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire desf_byte_type reg_addr,
  input  wire desf_byte_type reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  desf_byte_type reg_rdata,
  input  wire logic          a_sync_err,
  input  wire logic          a_csum_err,
  input  wire logic          a_hdr_unfix_err,
  input  wire logic          a_hdr_fix_err,
  input  wire logic          a_sot_sync_err,
  input  wire logic          a_eot_sync_err,
  input  wire logic          a_escape_err,
  input  wire logic          a_lp_sync_err,
  input  wire logic          a_false_ctrl_err,
  input  wire logic          a_lane_merge_err,
  input  wire logic          a_leader_bit_err,
  input  wire logic          b_sync_err,
  input  wire logic          b_csum_err,
  input  wire logic          b_hdr_unfix_err,
  input  wire logic          b_hdr_fix_err,
  input  wire logic          b_sot_sync_err,
  input  wire logic          b_eot_sync_err,
  input  wire logic          b_escape_err,
  input  wire logic          b_lp_sync_err,
  input  wire logic          b_false_ctrl_err,
  input  wire logic          b_lane_merge_err,
  input  wire logic          b_leader_bit_err,
  input  wire logic          pll_locked,
  output var  logic          irq_o,
  output var  logic          irq_oe
);
  desf_chan_type set_a;
  desf_chan_type set_b;
  desf_chan_type clr_a;
  desf_chan_type clr_b;
  desf_chan_type flags_a_q;
  desf_chan_type flags_b_q;
  desf_byte_type en_a_q;
  desf_byte_type en_b_q;
  desf_byte_type stat_a;
  desf_byte_type stat_b;
  desf_byte_type rdata_d;
  logic          irq_en_q;
  logic          pll_unlock_q;
  logic          lock_sync;
  logic          lock_prev_q;
  logic          unlock_evt;
  logic          wr_stat_a;
  logic          wr_stat_b;
  logic          pending;

  // event mapping, msb first: sync, checksum, unfix, fix, proto, leader
  always_comb begin
    set_a = {a_sync_err,
             a_csum_err,
             a_hdr_unfix_err,
             a_hdr_fix_err,
             a_sot_sync_err | a_eot_sync_err | a_escape_err |
             a_lp_sync_err | a_false_ctrl_err |
             a_lane_merge_err,
             a_leader_bit_err};
    set_b = {b_sync_err,
             b_csum_err,
             b_hdr_unfix_err,
             b_hdr_fix_err,
             b_sot_sync_err | b_eot_sync_err | b_escape_err |
             b_lp_sync_err | b_false_ctrl_err |
             b_lane_merge_err,
             b_leader_bit_err};
  end

  assign wr_stat_a = reg_wr && (reg_addr == `DESF_ADDR_STAT_A);
  assign wr_stat_b = reg_wr && (reg_addr == `DESF_ADDR_STAT_B);
  // only the flag field of the written byte clears these flags; bit 0 of a channel a write clears the unlock flag
  assign clr_a = wr_stat_a
    ? reg_wdata[`DESF_CHAN_LSB +: `DESF_CHAN_BITS] : '0;
  assign clr_b = wr_stat_b
    ? reg_wdata[`DESF_CHAN_LSB +: `DESF_CHAN_BITS] : '0;

  desf_chan_flags u_flags_a (
    .clk      (clk),
    .rstn     (rstn),
    .set_evt  (set_a),
    .clr_ones (clr_a),
    .flags_q  (flags_a_q)
  );

  desf_chan_flags u_flags_b (
    .clk      (clk),
    .rstn     (rstn),
    .set_evt  (set_b),
    .clr_ones (clr_b),
    .flags_q  (flags_b_q)
  );

  // lock comes from the pll domain; start as locked so reset makes no event
  desf_sync3 #(
    .RESET_VAL (1'b1)
  ) u_lock_sync (
    .clk       (clk),
    .rstn      (rstn),
    .async_in  (pll_locked),
    .level_out (lock_sync)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_prev_q <= 1'b1;
    end else begin
      lock_prev_q <= lock_sync;
    end
  end

  assign unlock_evt = lock_prev_q && !lock_sync;

  // unlock flag reads one after reset: the pll has not locked yet
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pll_unlock_q <= `DESF_RESET_UNLOCK;
    end else if (unlock_evt) begin
      pll_unlock_q <= 1'b1;
    end else if (wr_stat_a && reg_wdata[`DESF_BIT_PLL_UNLOCK]) begin
      pll_unlock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_en_q <= 1'b0;
    end else if (reg_wr && reg_addr == `DESF_ADDR_IRQ_CTRL) begin
      irq_en_q <= reg_wdata[`DESF_BIT_IRQ_EN];
    end
  end

  // reserved enable bits are not stored, so they read back as zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_a_q <= `DESF_ZERO_BYTE;
      en_b_q <= `DESF_ZERO_BYTE;
    end else if (reg_wr && reg_addr == `DESF_ADDR_EN_A) begin
      en_a_q <= reg_wdata & `DESF_MASK_A;
    end else if (reg_wr && reg_addr == `DESF_ADDR_EN_B) begin
      en_b_q <= reg_wdata & `DESF_MASK_B;
    end
  end

  // reserved status bits read zero
  assign stat_a = {flags_a_q, 1'b0, pll_unlock_q};
  assign stat_b = {flags_b_q, 2'b00};

  always_comb begin
    rdata_d = `DESF_ZERO_BYTE;
    unique case (reg_addr)
      `DESF_ADDR_IRQ_CTRL: rdata_d = {7'h00, irq_en_q};
      `DESF_ADDR_EN_A:     rdata_d = en_a_q;
      `DESF_ADDR_EN_B:     rdata_d = en_b_q;
      `DESF_ADDR_STAT_A:   rdata_d = stat_a;
      `DESF_ADDR_STAT_B:   rdata_d = stat_b;
      default:             rdata_d = `DESF_ZERO_BYTE;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= `DESF_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `DESF_ZERO_BYTE;
    end
  end

  assign pending = |(stat_a & en_a_q) || |(stat_b & en_b_q);

  // registered output adds one cycle from flag to pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_o  <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= irq_en_q && pending;
      irq_o  <= irq_en_q && pending;
    end
  end
endmodule // desf_top
`default_nettype wire

/* File: testbench/desf_asserts.sv */
// checker on the top ports of the error flag block
// assumes one clock domain; bound to desf_top below
`timescale 1ns/100ps
`default_nettype none
module desf_asserts
  import desf_pkg::*;
(
  input wire logic          clk,
  input wire logic          rstn,
  input wire desf_byte_type reg_addr,
  input wire desf_byte_type reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire desf_byte_type reg_rdata,
  input wire logic          a_sync_err,
  input wire logic          a_lane_merge_err,
  input wire logic          b_sync_err,
  input wire logic          irq_o,
  input wire logic          irq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  AST_PIN_PAIR: assert property (
    irq_o == irq_oe) else $error("irq value and enable differ");
  AST_A_SYNC: assert property (
    a_sync_err ##1 (reg_rd && reg_addr == 8'hE5) |=> reg_rdata[7])
    else $error("a sync flag not set");
  AST_MERGE: assert property (
    a_lane_merge_err ##1 (reg_rd && reg_addr == 8'hE5) |=> reg_rdata[3])
    else $error("merge fault missing");
  AST_B_SYNC: assert property (
    b_sync_err ##1 (reg_rd && reg_addr == 8'hE6) |=> reg_rdata[7])
    else $error("b sync flag not set");
  AST_B_RSVD: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'hE6 |-> reg_rdata[1:0] == 2'h0)
    else $error("b reserved bits set");
  AST_IRQ_OFF: assert property (
    reg_wr && reg_addr == 8'hE0 && !reg_wdata[0] |-> ##2 !irq_oe)
    else $error("irq driven while disabled");
  AST_W1C: assert property (
    (reg_wr && reg_addr == 8'hE6 && reg_wdata[7] && !b_sync_err) ##1
    (reg_rd && reg_addr == 8'hE6) |=> !reg_rdata[7])
    else $error("b sync flag not cleared");
  cover property (irq_oe);
  cover property (reg_wr && reg_addr == 8'hE6);
  cover property (a_lane_merge_err);
endmodule // desf_asserts
bind desf_top desf_asserts u_asserts (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .a_sync_err(a_sync_err), .a_lane_merge_err(a_lane_merge_err),
  .b_sync_err(b_sync_err), .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

/* File: testbench/desf_host_model.sv */
// packet processor events of both channels and the pll lock level
// assumes requests on clk; bits 0-10 channel a, 11-21 channel b
`timescale 1ns/100ps
`default_nettype none
module desf_host_model (
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [4:0]  idx,
  input  wire logic        unlock,
  output var  logic [21:0] err,
  output var  logic        pll_locked
);
  // one-cycle pulse: a held level would set the flag again after a clear
  always_ff @(posedge clk) begin
    err <= fire ? 22'h1 << idx : 22'h0;
    pll_locked <= !unlock;
  end
endmodule // desf_host_model
`default_nettype wire

/* File: testbench/desf_top_bench.sv */
// self-checking bench for the error status flag block
// assumes package, design, checker and host model compiled first
`timescale 1ns/100ps
`default_nettype none
module desf_top_bench import desf_pkg::*;;
  logic          clk, rstn, reg_wr, reg_rd, irq_o, irq_oe;
  logic          fire, unlock, pll_locked, rd_d;
  logic [4:0]    idx;
  logic [21:0]   err;
  desf_byte_type reg_addr, reg_wdata, reg_rdata, a, m;
  desf_byte_type exq[$];
  desf_byte_type st[2];
  int            miscompares, checks, cyc;
  int            bitpos[11] = '{7, 6, 5, 4, 3, 3, 3, 3, 3, 3, 2};
  desf_top u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .a_sync_err(err[0]), .a_csum_err(err[1]), .a_hdr_unfix_err(err[2]),
    .a_hdr_fix_err(err[3]), .a_sot_sync_err(err[4]),
    .a_eot_sync_err(err[5]), .a_escape_err(err[6]),
    .a_lp_sync_err(err[7]), .a_false_ctrl_err(err[8]),
    .a_lane_merge_err(err[9]), .a_leader_bit_err(err[10]),
    .b_sync_err(err[11]), .b_csum_err(err[12]), .b_hdr_unfix_err(err[13]),
    .b_hdr_fix_err(err[14]), .b_sot_sync_err(err[15]),
    .b_eot_sync_err(err[16]), .b_escape_err(err[17]),
    .b_lp_sync_err(err[18]), .b_false_ctrl_err(err[19]),
    .b_lane_merge_err(err[20]), .b_leader_bit_err(err[21]),
    .pll_locked(pll_locked), .irq_o(irq_o), .irq_oe(irq_oe));
  desf_host_model u_host (.clk(clk), .fire(fire), .idx(idx),
    .unlock(unlock), .err(err), .pll_locked(pll_locked));
  task automatic chk(string what, desf_byte_type e, desf_byte_type g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // strobes stay up so calls run back to back
  task automatic acc(logic w, desf_byte_type ad, desf_byte_type d,
                     desf_byte_type e);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= d;
    if (!w)
      exq.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // returns at the edge where the design samples the event
  task automatic pulse(int ch, int i);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    fire <= 1'b1;
    idx <= 5'(ch * 11 + i);
    @(posedge clk);
    fire <= 1'b0;
    st[ch][bitpos[i]] = 1'b1;
    @(posedge clk);
  endtask
  task automatic pin(desf_byte_type e);
    idle();
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq pin", e, {6'h00, irq_o, irq_oe});
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk)
    if (rd_d)
      chk("read data", exq.pop_front(), reg_rdata);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  initial begin
    {rstn, reg_wr, reg_rd, fire, unlock} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    idx = 5'h00;
    void'($urandom(32'hE457));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    acc(1'b0, 8'hE5, 8'h00, 8'h01);
    acc(1'b0, 8'hE6, 8'h00, 8'h00);
    acc(1'b1, 8'h10, 8'hFF, 8'h00);
    acc(1'b0, 8'h10, 8'h00, 8'h00);
    m = 8'($urandom);
    acc(1'b1, 8'hE1, m, 8'h00);
    acc(1'b1, 8'hE2, m, 8'h00);
    acc(1'b1, 8'hE5, 8'h01, 8'h00);
    acc(1'b0, 8'hE1, 8'h00, m & 8'hFD);
    acc(1'b0, 8'hE2, 8'h00, m & 8'hFC);
    acc(1'b0, 8'hE5, 8'h00, 8'h00);
    acc(1'b1, 8'hE1, 8'h00, 8'h00);
    st = '{8'h00, 8'h00};
    for (int ch = 0; ch < 2; ch++)
      for (int i = 0; i < 11; i++) begin
        m = 8'h01 << bitpos[i];
        a = ch ? 8'hE6 : 8'hE5;
        pulse(ch, i);
        acc(1'b0, a, 8'h00, st[ch]);
        acc(1'b0, a ^ 8'h03, 8'h00, st[1 - ch]);
        acc(1'b1, a, 8'($urandom) & ~m, 8'h00);
        acc(1'b0, a, 8'h00, st[ch]);
        acc(1'b1, a, m, 8'h00);
        st[ch] = 8'h00;
        acc(1'b0, a, 8'h00, 8'h00);
      end
    acc(1'b1, 8'hE1, 8'h80, 8'h00);
    acc(1'b1, 8'hE0, 8'h01, 8'h00);
    pulse(0, 0);
    pin(8'h03);
    acc(1'b1, 8'hE0, 8'h00, 8'h00);
    pin(8'h00);
    acc(1'b1, 8'hE0, 8'h01, 8'h00);
    acc(1'b1, 8'hE1, 8'h00, 8'h00);
    pin(8'h00);
    acc(1'b1, 8'hE1, 8'h80, 8'h00);
    pin(8'h03);
    acc(1'b1, 8'hE5, 8'h80, 8'h00);
    pin(8'h00);
    unlock <= 1'b1;
    repeat (10) @(posedge clk);
    unlock <= 1'b0;
    acc(1'b0, 8'hE5, 8'h00, 8'h01);
    acc(1'b1, 8'hE5, 8'h01, 8'h00);
    acc(1'b0, 8'hE5, 8'h00, 8'h00);
    idle();
    @(posedge clk);
    tally_and_finish();
  end
endmodule // desf_top_bench
`default_nettype wire
